// ===== ioac_pkg.sv
// Purpose: Constants for the indexed operand address calculator.
// Assumes: Specifier bytes arrive one per accepted cycle, lowest byte first.
// Notes: Size codes are the log2 of the operand size in bytes.
// Function
// [RULE1] Word operands use the index times two added to the evaluated base address.
// [RULE2] An autoincrement base takes the base register as base, then adds the scaled index.
// [RULE3] A longword operand spans the indexed byte and the three bytes after it.
// [RULE4] An autoincrement deferred base reads the longword at the register as base address.
// [RULE5] An autodecrement base lowers the register by the size first and keeps that value.
// [RULE6] An absolute base is the 32-bit address that follows in the stream.
// [RULE7] A displacement base is the register plus the sign-extended displacement.
// [RULE8] A quadword spans eight bytes and the index is scaled by eight.
// [RULE9] A displacement deferred base is the longword read at register plus displacement.
// [RULE10] A specifier with upper nibble four is index mode naming the index register.
// [RULE11] A base specifier with upper nibble eight is autoincrement mode.
// [RULE12] A base specifier with upper nibble seven is autodecrement mode.
// [RULE13] A base specifier with upper nibble six is register deferred mode.
// [RULE14] The index is scaled by one, two, four or eight bytes by operand size.
// [RULE15] Register, literal or index mode as base raises an illegal mode fault.
// [RULE16] The program counter as index register raises a reserved mode fault.
// [RULE17] All additions are 32-bit wraparound with the carry discarded.
package ioac_pkg;
   // ==========================================================
   // Specifier mode nibbles
   localparam logic [3:0] M_LIT_MAX = 4'h3;
   localparam logic [3:0] M_INDEX = 4'h4;
   localparam logic [3:0] M_REG = 4'h5;
   localparam logic [3:0] M_REGDEF = 4'h6;
   localparam logic [3:0] M_AUTODEC = 4'h7;
   localparam logic [3:0] M_AUTOINC = 4'h8;
   localparam logic [3:0] M_AINCDEF = 4'h9;
   localparam logic [3:0] M_BDISP = 4'ha;
   localparam logic [3:0] M_BDISPDEF = 4'hb;
   localparam logic [3:0] M_WDISP = 4'hc;
   localparam logic [3:0] M_WDISPDEF = 4'hd;
   localparam logic [3:0] M_LDISP = 4'he;
   localparam logic [3:0] M_LDISPDEF = 4'hf;
   localparam logic [3:0] PC_REG = 4'hf;
   // ==========================================================
   // Operand size codes and extension lengths
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_WORD = 2'h1;
   localparam logic [1:0] SZ_LONG = 2'h2;
   localparam logic [1:0] SZ_QUAD = 2'h3;
   localparam logic [2:0] EXT_B = 3'h1;
   localparam logic [2:0] EXT_W = 3'h2;
   localparam logic [2:0] EXT_L = 3'h4;
   localparam logic [31:0] PTR_BYTES = 32'h4;
   // ==========================================================
   // One-hot sequencer states
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_BASE = 6'h02,
      ST_EXT = 6'h04,
      ST_REG = 6'h08,
      ST_MEM = 6'h10
   } ioac_state_e;
endpackage

// ===== ioac_calc.sv
// Purpose: Forms the operand address of an indexed operand specifier.
// Assumes: rf_rd_data follows rf_rd_idx combinationally in the same cycle.
// Notes: Non-index first bytes are consumed with no result.
`timescale 1ns/1ps
module ioac_calc
   import ioac_pkg::*;
(
   input wire logic sys_clk, // 100 MHz clock.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic spec_valid, // Specifier byte offered.
   input wire logic [7:0] spec_byte, // Specifier or extension byte.
   input wire logic [1:0] op_size, // Size code, taken with index byte.
   output logic spec_ready, // Byte taken when valid and ready.
   output logic [3:0] rf_rd_idx, // Register file read select.
   input wire logic [31:0] rf_rd_data, // Register file read data.
   output logic rf_wr_en, // Base register update pulse.
   output logic [3:0] rf_wr_idx, // Updated base register.
   output logic [31:0] rf_wr_data, // New base register value.
   output logic mem_rd_req, // Longword read, held until answered.
   output logic [31:0] mem_addr, // Longword read address.
   input wire logic mem_rd_valid, // Read data valid pulse.
   input wire logic [31:0] mem_rd_data, // Longword read data.
   output logic addr_valid, // Indexed address ready pulse.
   output logic [31:0] addr_out, // Indexed operand address.
   output logic [3:0] addr_bytes, // Bytes the operand spans.
   output logic fault_illegal, // Illegal base mode pulse.
   output logic fault_reserved // Program counter as index pulse.
);
   // ==========================================================
   // State
   ioac_state_e state, next_state;
   logic [1:0] size, next_size;
   logic [3:0] mode, next_mode;
   logic [3:0] base_register, next_base_register;
   logic [31:0] idx, next_idx;
   logic [31:0] disp, next_disp;
   logic [2:0] ecnt, next_ecnt;
   logic [2:0] elen, next_elen;
   logic [31:0] base, next_base;
   logic next_spec_ready, next_rf_wr_en, next_mem_rd_req, next_addr_valid;
   logic next_fault_illegal, next_fault_reserved;
   logic [3:0] next_rf_rd_idx, next_rf_wr_idx, next_addr_bytes;
   logic [31:0] next_rf_wr_data, next_mem_addr, next_addr_out;
   logic take;
   logic [31:0] size_bytes, idx_off;

   // Size in bytes and scaled index; the shift drops bits above 31.
   assign take = spec_valid && spec_ready;
   assign size_bytes = 32'h1 << size; // see [RULE14]
   assign idx_off = idx << size; // see [RULE1] see [RULE8] see [RULE14]

   // Extension byte count for a base mode; absolute carries a longword.
   function automatic logic [2:0] ext_len(input logic [3:0] m, input logic [3:0] r);
      case (m)
         M_BDISP, M_BDISPDEF: ext_len = EXT_B;
         M_WDISP, M_WDISPDEF: ext_len = EXT_W;
         M_LDISP, M_LDISPDEF: ext_len = EXT_L;
         M_AINCDEF: ext_len = (r == PC_REG) ? EXT_L : 3'h0; // see [RULE6]
         default: ext_len = 3'h0;
      endcase
   endfunction

   // ==========================================================
   // Next-state logic for the whole sequence
   always_comb
   begin
      logic [31:0] acc;
      logic [31:0] nb;
      logic go_mem;
      acc = 32'h0;
      nb = base;
      go_mem = 1'b0;
      next_state = state;
      next_size = size;
      next_mode = mode;
      next_base_register = base_register;
      next_idx = idx;
      next_disp = disp;
      next_ecnt = ecnt;
      next_elen = elen;
      next_base = base;
      next_rf_rd_idx = rf_rd_idx;
      next_rf_wr_en = 1'b0;
      next_rf_wr_idx = rf_wr_idx;
      next_rf_wr_data = rf_wr_data;
      next_mem_rd_req = mem_rd_req;
      next_mem_addr = mem_addr;
      next_addr_valid = 1'b0;
      next_addr_out = addr_out;
      next_addr_bytes = addr_bytes;
      next_fault_illegal = 1'b0;
      next_fault_reserved = 1'b0;
      case (state)
         ST_IDLE:
         begin
            if (take && spec_byte[7:4] == M_INDEX) // see [RULE10]
            begin
               if (spec_byte[3:0] == PC_REG)
                  next_fault_reserved = 1'b1; // see [RULE16]
               else
               begin
                  next_size = op_size;
                  next_rf_rd_idx = spec_byte[3:0];
                  next_state = ST_BASE;
               end
            end
         end
         ST_BASE:
         begin
            if (take)
            begin
               // The index read has been steady since the index byte.
               next_idx = rf_rd_data;
               next_mode = spec_byte[7:4];
               next_base_register = spec_byte[3:0];
               next_rf_rd_idx = spec_byte[3:0];
               next_disp = 32'h0;
               next_ecnt = 3'h0;
               next_elen = ext_len(spec_byte[7:4], spec_byte[3:0]);
               if (spec_byte[7:4] <= M_REG) // see [RULE15]
               begin
                  next_fault_illegal = 1'b1;
                  next_state = ST_IDLE;
               end
               else if (next_elen != 3'h0)
                  next_state = ST_EXT;
               else
                  next_state = ST_REG;
            end
         end
         ST_EXT:
         begin
            if (take)
            begin
               // Extension bytes arrive lowest first.
               acc = disp | ({24'h0, spec_byte} << {ecnt, 3'b000});
               next_ecnt = ecnt + 3'h1;
               next_disp = acc;
               if (next_ecnt == elen)
               begin
                  // Sign extension makes short displacements reach backward.
                  if (elen == EXT_B)
                     next_disp = {{24{acc[7]}}, acc[7:0]}; // see [RULE7]
                  else if (elen == EXT_W)
                     next_disp = {{16{acc[15]}}, acc[15:0]}; // see [RULE7]
                  next_state = ST_REG;
               end
            end
         end
         ST_REG:
         begin
            // Base register value is on rf_rd_data in this cycle.
            next_rf_wr_idx = base_register;
            case (mode)
               M_REGDEF: nb = rf_rd_data; // see [RULE13]
               M_AUTODEC: // see [RULE12]
               begin
                  nb = rf_rd_data - size_bytes; // see [RULE5]
                  next_rf_wr_en = 1'b1;
                  next_rf_wr_data = nb;
               end
               M_AUTOINC: // see [RULE11]
               begin
                  nb = rf_rd_data; // see [RULE2]
                  next_rf_wr_en = 1'b1;
                  next_rf_wr_data = rf_rd_data + size_bytes; // see [RULE17]
               end
               M_AINCDEF:
               begin
                  if (base_register == PC_REG)
                     nb = disp; // see [RULE6]
                  else
                  begin
                     go_mem = 1'b1;
                     next_mem_addr = rf_rd_data; // see [RULE4]
                     next_rf_wr_en = 1'b1;
                     next_rf_wr_data = rf_rd_data + PTR_BYTES;
                  end
               end
               M_BDISP, M_WDISP, M_LDISP: nb = rf_rd_data + disp; // see [RULE7]
               default:
               begin
                  go_mem = 1'b1;
                  next_mem_addr = rf_rd_data + disp; // see [RULE9]
               end
            endcase
            if (go_mem)
            begin
               next_mem_rd_req = 1'b1;
               next_state = ST_MEM;
            end
         end
         ST_MEM:
         begin
            if (mem_rd_valid)
            begin
               nb = mem_rd_data; // see [RULE4] see [RULE9]
               next_mem_rd_req = 1'b0;
            end
         end
         default: next_state = ST_IDLE;
      endcase
      // Finish: base plus scaled index, 32-bit wraparound.
      if ((state == ST_REG && !go_mem) || (state == ST_MEM && mem_rd_valid))
      begin
         next_base = nb;
         next_addr_out = nb + idx_off; // see [RULE17] see [RULE2]
         next_addr_bytes = size_bytes[3:0]; // see [RULE3] see [RULE8]
         next_addr_valid = 1'b1;
         next_state = ST_IDLE;
      end
      // Ready is a flop, so it looks at the state being entered.
      next_spec_ready = (next_state == ST_IDLE) || (next_state == ST_BASE)
         || (next_state == ST_EXT);
   end

   // ==========================================================
   // Registers
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         size <= SZ_BYTE;
         mode <= 4'h0;
         base_register <= 4'h0;
         idx <= 32'h0;
         disp <= 32'h0;
         ecnt <= 3'h0;
         elen <= 3'h0;
         base <= 32'h0;
         spec_ready <= 1'b1;
         rf_rd_idx <= 4'h0;
         rf_wr_en <= 1'b0;
         rf_wr_idx <= 4'h0;
         rf_wr_data <= 32'h0;
         mem_rd_req <= 1'b0;
         mem_addr <= 32'h0;
         addr_valid <= 1'b0;
         addr_out <= 32'h0;
         addr_bytes <= 4'h0;
         fault_illegal <= 1'b0;
         fault_reserved <= 1'b0;
      end
      else
      begin
         state <= next_state;
         size <= next_size;
         mode <= next_mode;
         base_register <= next_base_register;
         idx <= next_idx;
         disp <= next_disp;
         ecnt <= next_ecnt;
         elen <= next_elen;
         base <= next_base;
         spec_ready <= next_spec_ready;
         rf_rd_idx <= next_rf_rd_idx;
         rf_wr_en <= next_rf_wr_en;
         rf_wr_idx <= next_rf_wr_idx;
         rf_wr_data <= next_rf_wr_data;
         mem_rd_req <= next_mem_rd_req;
         mem_addr <= next_mem_addr;
         addr_valid <= next_addr_valid;
         addr_out <= next_addr_out;
         addr_bytes <= next_addr_bytes;
         fault_illegal <= next_fault_illegal;
         fault_reserved <= next_fault_reserved;
      end
   end

   // ==========================================================
   // Assertions and covers
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   word_scale_a: assert property (addr_valid && size == SZ_WORD // see [RULE1]
      |-> addr_out == base + {idx[30:0], 1'b0})
      else $error("word index not scaled by two");
   autoinc_base_a: assert property (state == ST_REG && mode == M_AUTOINC // see [RULE2]
      |=> addr_valid && base == $past(rf_rd_data) && rf_wr_en
      && rf_wr_data == $past(rf_rd_data) + size_bytes)
      else $error("autoincrement base or update wrong");
   long_span_a: assert property (addr_valid && size == SZ_LONG // see [RULE3]
      |-> addr_bytes == 4'h4)
      else $error("longword span not four bytes");
   defer_read_a: assert property (state == ST_REG && mode == M_AINCDEF // see [RULE4]
      && base_register != PC_REG |=> mem_rd_req && mem_addr == $past(rf_rd_data)
      ##[1:200] addr_valid)
      else $error("deferred pointer read wrong");
   autodec_keep_a: assert property (state == ST_REG && mode == M_AUTODEC // see [RULE5]
      |=> rf_wr_en && rf_wr_data == base && base == $past(rf_rd_data) - size_bytes)
      else $error("autodecrement value wrong");
   abs_long_a: assert property (addr_valid && size == SZ_LONG && mode == M_AINCDEF // see [RULE6]
      && base_register == PC_REG |-> base == disp && addr_out == base + {idx[29:0], 2'b00})
      else $error("absolute indexed address wrong");
   quad_scale_a: assert property (addr_valid && size == SZ_QUAD // see [RULE8]
      |-> addr_bytes == 4'h8 && addr_out == base + {idx[28:0], 3'b000})
      else $error("quadword scaling wrong");
   index_dec_a: assert property (take && state == ST_IDLE // see [RULE10]
      && spec_byte[7:4] == M_INDEX && spec_byte[3:0] != PC_REG
      |=> state == ST_BASE && rf_rd_idx == $past(spec_byte[3:0]))
      else $error("index specifier not decoded");
   illegal_base_a: assert property (take && state == ST_BASE // see [RULE15]
      && spec_byte[7:4] <= M_REG |=> fault_illegal && !addr_valid ##1 !fault_illegal)
      else $error("illegal base not faulted");
   pc_index_a: assert property (take && state == ST_IDLE // see [RULE16]
      && spec_byte == {M_INDEX, PC_REG} |=> fault_reserved && state == ST_IDLE)
      else $error("program counter index not faulted");

   regdef_c: cover property (state == ST_REG && mode == M_REGDEF ##1 addr_valid);
   disp_def_c: cover property (state == ST_MEM && mode == M_BDISPDEF ##[1:20] addr_valid);
   absolute_c: cover property (addr_valid && mode == M_AINCDEF && base_register == PC_REG);
   fault_c: cover property (fault_illegal);
endmodule

// ===== ioac_far_model.sv
// Purpose: Register file and memory seen by the indexed address calculator.
// Assumes: The bench presets regs, lat and mem_val between operands.
// Notes: Read data turns to garbage once the one-cycle answer is gone.
`timescale 1ns/1ps
module ioac_far_model
(
   input wire logic sys_clk, // Clock.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic [3:0] rf_rd_idx, // Register read select.
   output logic [31:0] rf_rd_data, // Register read data.
   input wire logic rf_wr_en, // Register write pulse.
   input wire logic [3:0] rf_wr_idx, // Register written.
   input wire logic [31:0] rf_wr_data, // Value written.
   input wire logic mem_rd_req, // Longword read request.
   input wire logic [31:0] mem_addr, // Read address.
   output logic mem_rd_valid, // Answer pulse.
   output logic [31:0] mem_rd_data // Answer data.
);
   logic [31:0] regs [16];
   logic [31:0] mem_val = 32'h0;
   logic [31:0] seen_addr = 32'h0;
   int lat = 0;
   int cnt = 0;
   initial mem_rd_valid = 1'b0;
   initial mem_rd_data = 32'h0;
   initial foreach (regs[i]) regs[i] = 32'h0;
   // The register file is combinational, as the calculator expects.
   assign rf_rd_data = regs[rf_rd_idx];
   // ==========================================================
   // Memory answers after lat idle cycles, then inverts its bus every cycle so
   // that a sample one cycle late never sees the old longword.
   always @(posedge sys_clk)
   begin
      if (rf_wr_en)
         regs[rf_wr_idx] <= rf_wr_data;
      mem_rd_valid <= 1'b0;
      mem_rd_data <= ~mem_rd_data;
      if (!rst_n || !mem_rd_req)
         cnt <= 0;
      else if (!mem_rd_valid)
      begin
         if (cnt >= lat)
         begin
            mem_rd_valid <= 1'b1;
            mem_rd_data <= mem_val;
            seen_addr <= mem_addr;
            cnt <= 0;
         end
         else
            cnt <= cnt + 1;
      end
   end
endmodule

// ===== indexed_operand_address_calc_tb_top.sv
// Purpose: Self-checking bench for the indexed operand address calculator.
// Assumes: Inputs change at the falling edge only.
// Notes: Each scenario but t_faults presets registers, sends a specifier and judges.
`timescale 1ns/1ps
module indexed_operand_address_calc_tb_top;
   import ioac_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic spec_valid = 1'b0;
   logic [7:0] spec_byte = 8'h00;
   logic [1:0] op_size = 2'h0;
   logic spec_ready, rf_wr_en, mem_rd_req, mem_rd_valid;
   logic addr_valid, fault_illegal, fault_reserved;
   logic [3:0] rf_rd_idx, rf_wr_idx, addr_bytes, got_bytes;
   logic [31:0] rf_rd_data, rf_wr_data, mem_addr, mem_rd_data, addr_out, got_addr;
   logic got_ill, got_res;
   int num_errors = 0;
   int samples_checked = 0;
   // Free-running 100 MHz clock.
   always #5 sys_clk = ~sys_clk;
   ioac_calc u_ioac_calc (.sys_clk(sys_clk), .rst_n(rst_n), .spec_valid(spec_valid),
      .spec_byte(spec_byte), .op_size(op_size), .spec_ready(spec_ready),
      .rf_rd_idx(rf_rd_idx), .rf_rd_data(rf_rd_data), .rf_wr_en(rf_wr_en),
      .rf_wr_idx(rf_wr_idx), .rf_wr_data(rf_wr_data), .mem_rd_req(mem_rd_req),
      .mem_addr(mem_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
      .addr_valid(addr_valid), .addr_out(addr_out), .addr_bytes(addr_bytes),
      .fault_illegal(fault_illegal), .fault_reserved(fault_reserved));
   ioac_far_model u_ioac_far_model (.sys_clk(sys_clk), .rst_n(rst_n),
      .rf_rd_idx(rf_rd_idx), .rf_rd_data(rf_rd_data), .rf_wr_en(rf_wr_en),
      .rf_wr_idx(rf_wr_idx), .rf_wr_data(rf_wr_data), .mem_rd_req(mem_rd_req),
      .mem_addr(mem_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data));
   // ==========================================================
   // Shared helpers.
   task automatic wrap_up();
      if (num_errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic send(input logic [7:0] b[$]);
      foreach (b[i])
      begin
         @(negedge sys_clk);
         spec_valid = 1'b1;
         spec_byte = b[i];
      end
   endtask
   // Drops valid at the next falling edge and waits, bounded, for a result.
   task automatic wait_res();
      int n;
      n = 0;
      do
      begin
         @(negedge sys_clk);
         spec_valid = 1'b0;
         n++;
      end
      while (!(addr_valid === 1'b1 || fault_illegal === 1'b1 || fault_reserved === 1'b1)
             && n < 100);
      if (n >= 100)
      begin
         num_errors++;
         $display("[ERR] %0t no result", $time);
      end
      got_addr = addr_out;
      got_bytes = addr_bytes;
      got_ill = fault_illegal;
      got_res = fault_reserved;
   endtask
   task automatic op(input logic [1:0] sz, input logic [7:0] b[$], input logic [31:0] ea,
                     input logic [3:0] eb);
      op_size = sz;
      send(b);
      wait_res();
      chk(got_addr, ea);
      chk({28'h0, got_bytes}, {28'h0, eb});
      chk({30'h0, got_ill, got_res}, 32'h0);
      chk({31'h0, spec_ready}, 32'h1);
   endtask
   task automatic setr(input int r, input logic [31:0] v);
      u_ioac_far_model.regs[r] = v;
   endtask
   // ==========================================================
   // Scenarios.
   task automatic t_regdef();
      setr(2, 32'h00001000);
      setr(5, 32'h00000003);
      op(SZ_WORD, '{8'h45, 8'h62}, 32'h00001006, 4'h2);
   endtask
   task automatic t_autoinc();
      setr(4, 32'h00002000);
      setr(5, 32'h00000003);
      op(SZ_LONG, '{8'h45, 8'h84}, 32'h0000200c, 4'h4);
      @(negedge sys_clk);
      chk(u_ioac_far_model.regs[4], 32'h00002004);
   endtask
   task automatic t_aincdef();
      setr(4, 32'h00003000);
      setr(5, 32'h00000005);
      u_ioac_far_model.mem_val = 32'h00001000;
      u_ioac_far_model.lat = 5;
      op(SZ_WORD, '{8'h45, 8'h94}, 32'h0000100a, 4'h2);
      chk(u_ioac_far_model.seen_addr, 32'h00003000);
      chk(u_ioac_far_model.regs[4], 32'h00003004);
   endtask
   task automatic t_autodec();
      setr(2, 32'h00001016);
      setr(4, 32'h00000003);
      op(SZ_WORD, '{8'h44, 8'h72}, 32'h0000101a, 4'h2);
      @(negedge sys_clk);
      chk(u_ioac_far_model.regs[2], 32'h00001014);
   endtask
   task automatic t_abs();
      setr(2, 32'h00000005);
      op(SZ_LONG, '{8'h42, 8'h9f, 8'h12, 8'h10, 8'h00, 8'h00}, 32'h00001026, 4'h4);
   endtask
   task automatic t_disp();
      setr(1, 32'h00001000);
      setr(3, 32'h00000005);
      op(SZ_QUAD, '{8'h43, 8'ha1, 8'h02}, 32'h0000102a, 4'h8);
      setr(1, 32'h00000001);
      setr(3, 32'h00000002);
      op(SZ_BYTE, '{8'h43, 8'hc1, 8'hfe, 8'hff}, 32'h00000001, 4'h1);
      // A longword displacement is not sign-extended; the sum wraps past bit 31.
      setr(1, 32'h80000000);
      setr(3, 32'h00000001);
      op(SZ_LONG, '{8'h43, 8'he1, 8'h00, 8'h00, 8'h00, 8'h80}, 32'h00000004, 4'h4);
   endtask
   task automatic t_dispdef();
      setr(1, 32'h00001012);
      setr(3, 32'h00000004);
      u_ioac_far_model.mem_val = 32'h44332211;
      u_ioac_far_model.lat = 0;
      op(SZ_LONG, '{8'h43, 8'hb1, 8'h14}, 32'h44332221, 4'h4);
      chk(u_ioac_far_model.seen_addr, 32'h00001026);
      // Word and longword deferred displacements; the word one reaches backward.
      u_ioac_far_model.mem_val = 32'h00002000;
      op(SZ_WORD, '{8'h43, 8'hd1, 8'hf0, 8'hff}, 32'h00002008, 4'h2);
      chk(u_ioac_far_model.seen_addr, 32'h00001002);
      op(SZ_QUAD, '{8'h43, 8'hf1, 8'h00, 8'h01, 8'h00, 8'h00}, 32'h00002020, 4'h8);
      chk(u_ioac_far_model.seen_addr, 32'h00001112);
   endtask
   // Base modes zero to five are refused; the program counter as index too.
   task automatic t_faults();
      op_size = SZ_LONG;
      send('{8'h4f});
      wait_res();
      chk({31'h0, got_res}, 32'h1);
      for (int m = 0; m < 6; m++)
      begin
         send('{8'h43, {m[3:0], 4'h1}});
         wait_res();
         chk({31'h0, got_ill}, 32'h1);
      end
   endtask
   // ==========================================================
   // Main sequence and watchdog.
   initial
   begin
      repeat (20) @(negedge sys_clk);
      rst_n = 1'b1;
      @(negedge sys_clk);
      t_regdef();
      t_autoinc();
      t_aincdef();
      t_autodec();
      t_abs();
      t_disp();
      t_dispdef();
      t_faults();
      wrap_up();
   end
   // Watchdog: the scenarios need about a hundred cycles, so 5000 means a hang.
   initial
   begin
      #50000;
      num_errors++;
      wrap_up();
   end
endmodule
